// file: design/tsm_core.sv
// Serial slave, registers and result formatting of the temperature sensor
`timescale 1ns/1ps
`default_nettype none
module tsm_core #(
    parameter int MEAS_CYC = tsm_pkg::MEAS_CYCLES,
    parameter int TIMEOUT_CYC = tsm_pkg::TIMEOUT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic smbClkIn,
    input wire logic smbDatIn,
    output logic smbDatOut,
    output logic smbDatOeN,
    input wire logic [10:0] remoteSample,
    input wire logic [7:0] localSample,
    input wire logic diodeOpen,
    input wire logic diodeShort,
    output logic alertOut,
    output logic alertOeN,
    output logic critOut,
    output logic critOeN
);
    import tsm_pkg::*;

    if (MEAS_CYC < 2 || MEAS_CYC >= (1 << CNT_W))
        $error("MEAS_CYC out of range");
    if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << CNT_W))
        $error("TIMEOUT_CYC out of range");

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK, S_WDATA,
        S_WDATA_ACK, S_RDATA, S_RACK, S_WAIT
    } tsm_state_t;

    // ------------------------------------------------------------
    // Pin synchronisers and bus events
    // ------------------------------------------------------------
    logic [2:0] sclSync;
    logic [2:0] sdaSync;
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclSync <= 3'h7;
            sdaSync <= 3'h7;
        end
        else
        begin
            sclSync <= {sclSync[1:0], smbClkIn};
            sdaSync <= {sdaSync[1:0], smbDatIn};
        end
    end
    wire scl = sclSync[1];
    wire sda = sdaSync[1];
    wire sclRise = sclSync[1] && !sclSync[2];
    wire sclFall = !sclSync[1] && sclSync[2];
    wire startEv = sclSync[1] && sclSync[2] && !sda && sdaSync[2];
    wire stopEv = sclSync[1] && sclSync[2] && sda && !sdaSync[2];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    tsm_state_t state;
    logic [7:0] shiftReg;
    logic [3:0] bitCnt;
    logic [7:0] pointer;
    logic [7:0] localTemp, remoteHi, remoteLo, status, cfgCtrl;
    logic [7:0] convRate, localHigh, localLow, remoteHigh, remoteLow;
    logic [7:0] remoteCrit, localCrit, hyst, filterCfg;
    logic [CNT_W-1:0] toCnt;
    logic [CNT_W-1:0] measCnt;
    logic [14:0] filt;
    logic [1:0] qCnt [3];
    logic sdaHold;
    logic rackNack;

    // Timeout when a line sits low outside idle
    wire lineLow = !scl || !sda;
    wire timeoutEv = (toCnt == CNT_W'(TIMEOUT_CYC));
    wire addrMatch = (shiftReg[7:1] == SLAVE_ADDR);
    wire lastBit = (bitCnt == 4'h8);

    // Read mux by held pointer; unmapped reads zero
    logic [7:0] rdData;
    always_comb
    begin
        unique case (pointer)
            RD_LOCAL: rdData = localTemp;
            RD_REMOTE_HI: rdData = remoteHi;
            RD_STATUS: rdData = status;
            RD_CONFIG: rdData = cfgCtrl;
            RD_RATE: rdData = convRate;
            RD_LOCAL_HIGH: rdData = localHigh;
            RD_LOCAL_LOW: rdData = localLow;
            RD_REMOTE_HIGH: rdData = remoteHigh;
            RD_REMOTE_LOW: rdData = remoteLow;
            RD_REMOTE_LO: rdData = remoteLo;
            RW_REMOTE_CRIT: rdData = remoteCrit;
            RW_LOCAL_CRIT: rdData = localCrit;
            RW_HYST: rdData = hyst;
            RW_FILTER: rdData = filterCfg;
            default: rdData = RST_ZERO;
        endcase
    end

    wire loadTx = sclFall && ((state == S_ADDR_ACK && shiftReg[0])
        || (state == S_RACK && !rackNack));
    wire statusRead = loadTx && (pointer == RD_STATUS);
    wire writeEv = sclFall && state == S_WDATA_ACK;

    // ------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= S_IDLE;
            bitCnt <= 4'h0;
            shiftReg <= 8'h00;
            sdaHold <= 1'b0;
            rackNack <= 1'b0;
            toCnt <= '0;
        end
        else
        begin
            toCnt <= (lineLow && state != S_IDLE && !timeoutEv) ?
                toCnt + 1'b1 : '0;
            if (timeoutEv || stopEv)
            begin
                state <= S_IDLE;
                sdaHold <= 1'b0;
            end
            else if (startEv)
            begin
                state <= S_ADDR;
                bitCnt <= 4'h0;
                sdaHold <= 1'b0;
            end
            else if (sclRise)
            begin
                // Master ack or nack both taken
                if (state == S_RACK)
                    rackNack <= sda;
                else if (state inside {S_ADDR, S_CMD, S_WDATA})
                begin
                    shiftReg <= {shiftReg[6:0], sda};
                    bitCnt <= bitCnt + 4'h1;
                end
            end
            else if (sclFall)
            begin
                unique case (state)
                    S_ADDR:
                        if (lastBit)
                        begin
                            state <= addrMatch ? S_ADDR_ACK : S_WAIT;
                            sdaHold <= addrMatch;
                        end
                    S_ADDR_ACK:
                    begin
                        bitCnt <= 4'h0;
                        if (shiftReg[0])
                        begin
                            state <= S_RDATA;
                            shiftReg <= {rdData[6:0], 1'b0};
                            sdaHold <= !rdData[7];
                        end
                        else
                        begin
                            state <= S_CMD;
                            sdaHold <= 1'b0;
                        end
                    end
                    S_CMD:
                        if (lastBit)
                        begin
                            state <= S_CMD_ACK;
                            sdaHold <= 1'b1;
                        end
                    S_CMD_ACK:
                    begin
                        state <= S_WDATA;
                        bitCnt <= 4'h0;
                        sdaHold <= 1'b0;
                    end
                    S_WDATA:
                        if (lastBit)
                        begin
                            state <= S_WDATA_ACK;
                            sdaHold <= 1'b1;
                        end
                    // One data byte only; extra bytes ignored
                    S_WDATA_ACK:
                    begin
                        state <= S_WAIT;
                        sdaHold <= 1'b0;
                    end
                    S_RDATA:
                    begin
                        bitCnt <= bitCnt + 4'h1;
                        if (bitCnt == 4'h7)
                        begin
                            state <= S_RACK;
                            sdaHold <= 1'b0;
                        end
                        else
                        begin
                            sdaHold <= !shiftReg[7];
                            shiftReg <= {shiftReg[6:0], 1'b0};
                        end
                    end
                    S_RACK:
                    begin
                        bitCnt <= 4'h0;
                        if (rackNack)
                            state <= S_WAIT;
                        else
                        begin
                            state <= S_RDATA;
                            shiftReg <= {rdData[6:0], 1'b0};
                            sdaHold <= !rdData[7];
                        end
                    end
                    S_IDLE, S_WAIT: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Measurement timing, filter and fault queue
    // ------------------------------------------------------------
    // Fixed measurement cycle length
    wire convEnd = (measCnt == CNT_W'(MEAS_CYC - 1));
    // Filter strength from the filter field
    wire [1:0] fltSel = filterCfg[FLT_LSB+1:FLT_LSB];
    wire [14:0] sampleExt = {remoteSample, 4'h0};
    wire signed [15:0] fltDiff = $signed({sampleExt[14], sampleExt})
        - $signed({filt[14], filt});
    wire signed [15:0] fltStep = (fltSel == 2'h3) ? fltDiff >>> 2 :
        fltDiff >>> 1;
    // Extra fraction bits and rounding keep the mean unbiased
    wire [14:0] next_filt = (fltSel == 2'h0) ? sampleExt :
        15'(filt + fltStep[14:0]);
    wire [15:0] fltRound = {next_filt[14], next_filt} + 16'h0008;
    wire [10:0] remoteVal = fltRound[14:4];
    // Shorted diode forces the low code
    wire [7:0] next_remoteHi = diodeOpen ? OPEN_CODE :
        diodeShort ? SHORT_CODE : remoteVal[10:3];
    wire [7:0] next_remoteLo = (diodeOpen || diodeShort) ? RST_ZERO :
        {remoteVal[2:0], 5'h00};
    wire [2:0] remoteOver = {
        $signed(next_remoteHi) > $signed(remoteHigh),
        $signed(next_remoteHi) < $signed(remoteLow),
        $signed(next_remoteHi) > $signed(remoteCrit)};
    logic [2:0] remoteFlag;
    logic [1:0] next_qCnt [3];
    for (genvar i = 0; i < 3; i++)
    begin : g_queue
        always_comb
        begin
            next_qCnt[i] = remoteOver[i] ? ((qCnt[i] == QUEUE_DEPTH) ?
                QUEUE_DEPTH : qCnt[i] + 2'h1) : 2'h0;
            remoteFlag[i] = cfgCtrl[CFG_QUEUE] ?
                (next_qCnt[i] == QUEUE_DEPTH) : remoteOver[i];
        end
        always_ff @(posedge sys_clk or negedge rstn)
        begin
            if (!rstn)
                qCnt[i] <= 2'h0;
            else if (convEnd)
                qCnt[i] <= next_qCnt[i];
        end
    end
    wire [7:0] convFlags = {1'b0,
        $signed(localSample) > $signed(localHigh),
        $signed(localSample) < $signed(localLow),
        remoteFlag[2], remoteFlag[1], diodeOpen, remoteFlag[0],
        $signed(localSample) > $signed(localCrit)};
    wire [7:0] stickyKeep = statusRead ? RST_ZERO : status;
    wire [7:0] next_status = (stickyKeep | (convEnd ? convFlags : 8'h00))
        & ~(8'h01 << ST_BUSY) | ({7'h00, !convEnd} << ST_BUSY);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pointer <= RST_ZERO;
            localTemp <= RST_ZERO;
            remoteHi <= RST_ZERO;
            remoteLo <= RST_ZERO;
            status <= RST_ZERO;
            cfgCtrl <= RST_ZERO;
            convRate <= RST_RATE;
            localHigh <= RST_HIGH;
            remoteHigh <= RST_HIGH;
            localLow <= RST_ZERO;
            remoteLow <= RST_ZERO;
            localCrit <= RST_CRIT;
            remoteCrit <= RST_CRIT;
            hyst <= RST_HYST;
            filterCfg <= RST_ZERO;
            measCnt <= '0;
            filt <= 15'h0000;
        end
        else
        begin
            measCnt <= convEnd ? '0 : measCnt + 1'b1;
            // Set by a finishing conversion wins over read clear
            status <= next_status;
            if (sclFall && state == S_CMD_ACK)
                pointer <= shiftReg;
            // Results only change at conversion end
            if (convEnd)
            begin
                localTemp <= localSample;
                remoteHi <= next_remoteHi;
                remoteLo <= next_remoteLo;
                if (!diodeOpen && !diodeShort)
                    filt <= next_filt;
            end
            // Only limits and controls are writable
            if (writeEv)
            begin
                unique case (pointer)
                    WR_CONFIG: cfgCtrl <= shiftReg;
                    WR_RATE: convRate <= shiftReg;
                    WR_LOCAL_HIGH: localHigh <= shiftReg;
                    WR_LOCAL_LOW: localLow <= shiftReg;
                    WR_REMOTE_HIGH: remoteHigh <= shiftReg;
                    WR_REMOTE_LOW: remoteLow <= shiftReg;
                    RW_REMOTE_CRIT: remoteCrit <= shiftReg;
                    RW_LOCAL_CRIT: localCrit <= shiftReg;
                    RW_HYST: hyst <= shiftReg;
                    RW_FILTER: filterCfg <= shiftReg;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Open-drain outputs
    // ------------------------------------------------------------
    // Open flag excluded from alert sources
    wire alertReq = |(status & ALARM_BITS) && !cfgCtrl[CFG_MASK];
    wire critReq = status[ST_RCRIT] || status[ST_LCRIT];
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            smbDatOut <= 1'b0;
            smbDatOeN <= 1'b1;
            alertOut <= 1'b0;
            alertOeN <= 1'b1;
            critOut <= 1'b0;
            critOeN <= 1'b1;
        end
        else
        begin
            smbDatOut <= 1'b0;
            smbDatOeN <= !sdaHold;
            alertOut <= 1'b0;
            alertOeN <= !alertReq;
            critOut <= 1'b0;
            critOeN <= !critReq;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_start_expects_addr: assert property (@(posedge sys_clk)
        disable iff (!rstn) startEv && !timeoutEv |=> state == S_ADDR)
        else $error("start did not restart address phase");
    a_timeout_to_idle: assert property (@(posedge sys_clk)
        disable iff (!rstn) timeoutEv |=> state == S_IDLE ##1 smbDatOeN)
        else $error("timeout did not release bus");
    a_ack_only_match: assert property (@(posedge sys_clk)
        disable iff (!rstn) state == S_ADDR_ACK |-> shiftReg[7:1] == 7'h4c)
        else $error("acked a foreign address");
    a_open_forced: assert property (@(posedge sys_clk)
        disable iff (!rstn) convEnd && diodeOpen
        |=> remoteHi == 8'h7f && remoteLo == 8'h00 && status[2])
        else $error("open diode code wrong");
    a_short_forced: assert property (@(posedge sys_clk)
        disable iff (!rstn) convEnd && diodeShort && !diodeOpen
        |=> remoteHi == 8'h80 && !status[2])
        else $error("shorted diode code wrong");
    a_low_byte_pad: assert property (@(posedge sys_clk)
        disable iff (!rstn) remoteLo[4:0] == 5'h00)
        else $error("low byte padding not zero");
    a_open_no_alert: assert property (@(posedge sys_clk)
        disable iff (!rstn) (status & 8'h7b) == 8'h00 |=> alertOeN)
        else $error("alert without alarm bit");
    a_queue_holds: assert property (@(posedge sys_clk)
        disable iff (!rstn) convEnd && cfgCtrl[0] && qCnt[2] == 2'h0
        && !status[4] |=> !status[4])
        else $error("queue raised high flag too early");
    a_status_sticky: assert property (@(posedge sys_clk)
        disable iff (!rstn) status[0] && !statusRead |=> status[0])
        else $error("alarm flag lost without read");
    a_meas_period: assert property (@(posedge sys_clk)
        disable iff (!rstn) convEnd |=> measCnt == '0 ##1 !convEnd)
        else $error("measurement counter did not restart");
endmodule
`default_nettype wire

// file: design/tsm_pkg.sv
// Constants shared by the temperature sensor serial core
package tsm_pkg;
    // ------------------------------------------------------------
    // Bus address and pointer codes
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h4c;
    localparam logic [7:0] RD_LOCAL = 8'h00;
    localparam logic [7:0] RD_REMOTE_HI = 8'h01;
    localparam logic [7:0] RD_STATUS = 8'h02;
    localparam logic [7:0] RD_CONFIG = 8'h03;
    localparam logic [7:0] RD_RATE = 8'h04;
    localparam logic [7:0] RD_LOCAL_HIGH = 8'h05;
    localparam logic [7:0] RD_LOCAL_LOW = 8'h06;
    localparam logic [7:0] RD_REMOTE_HIGH = 8'h07;
    localparam logic [7:0] RD_REMOTE_LOW = 8'h08;
    localparam logic [7:0] RD_REMOTE_LO = 8'h10;
    localparam logic [7:0] WR_CONFIG = 8'h09;
    localparam logic [7:0] WR_RATE = 8'h0a;
    localparam logic [7:0] WR_LOCAL_HIGH = 8'h0b;
    localparam logic [7:0] WR_LOCAL_LOW = 8'h0c;
    localparam logic [7:0] WR_REMOTE_HIGH = 8'h0d;
    localparam logic [7:0] WR_REMOTE_LOW = 8'h0e;
    localparam logic [7:0] RW_REMOTE_CRIT = 8'h19;
    localparam logic [7:0] RW_LOCAL_CRIT = 8'h20;
    localparam logic [7:0] RW_HYST = 8'h21;
    localparam logic [7:0] RW_FILTER = 8'hbf;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h08;
    localparam logic [7:0] RST_CRIT = 8'h55;
    localparam logic [7:0] RST_HIGH = 8'h46;
    localparam logic [7:0] RST_HYST = 8'h0a;
    // ------------------------------------------------------------
    // Field positions and fault codes
    // ------------------------------------------------------------
    localparam int ST_BUSY = 7;
    localparam int ST_LHIGH = 6;
    localparam int ST_LLOW = 5;
    localparam int ST_RHIGH = 4;
    localparam int ST_RLOW = 3;
    localparam int ST_OPEN = 2;
    localparam int ST_RCRIT = 1;
    localparam int ST_LCRIT = 0;
    localparam int CFG_MASK = 7;
    localparam int CFG_QUEUE = 0;
    localparam int FLT_LSB = 1;
    localparam logic [7:0] ALARM_BITS = 8'h7b;
    localparam logic [7:0] OPEN_CODE = 8'h7f;
    localparam logic [7:0] SHORT_CODE = 8'h80;
    localparam logic [1:0] QUEUE_DEPTH = 2'h3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int MEAS_TIME_NS = 31_250_000;
    localparam int TIMEOUT_NS = 35_000_000;
    localparam int MEAS_CYCLES = MEAS_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT_CYCLES =
        (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 21;
endpackage

// file: testbench/tsm_host.sv
// SMBus master model for the sensor core bench
`timescale 1ns/1ps
`default_nettype none
module tsm_host (
    input wire logic sys_clk,
    input wire logic sdaWire,
    output var logic sclDrv,
    output var logic sdaDrv
);
    import tsm_pkg::*;
    initial
    begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // clock held low, long holds force idle
    task automatic holdLow(input int n);
        sclDrv <= 1'b0;
        wt(n);
    endtask
    // Start is edges(1,0), stop is edges(0,1)
    task automatic edges(input logic a, input logic b);
        holdLow(2);
        sdaDrv <= a;
        wt(2);
        sclDrv <= 1'b1;
        wt(2);
        sdaDrv <= b;
        wt(2);
    endtask
    task automatic bitx(input logic b, output logic r);
        holdLow(2);
        sdaDrv <= b;
        wt(2);
        sclDrv <= 1'b1;
        wt(4);
        r = sdaWire;
    endtask
    // MSB first, ninth clock carries acknowledge
    task automatic xfer(input logic [7:0] d, input logic a,
        output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r[i]);
        bitx(a, ack);
    endtask
    task automatic wrReg(input logic [7:0] c, input logic [7:0] d,
        output logic [2:0] ack);
        logic [7:0] r;
        edges(1'b1, 1'b0);
        xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, ack[2]);
        xfer(c, 1'b1, r, ack[1]);
        xfer(d, 1'b1, r, ack[0]);
        edges(1'b0, 1'b1);
    endtask
    task automatic rdReg(input logic [7:0] c, output logic [7:0] d);
        logic [7:0] r;
        logic k;
        edges(1'b1, 1'b0);
        xfer({SLAVE_ADDR, 1'b0}, 1'b1, r, k);
        xfer(c, 1'b1, r, k);
        edges(1'b1, 1'b0);
        xfer({SLAVE_ADDR, 1'b1}, 1'b1, r, k);
        xfer(8'hff, 1'b1, d, k);
        edges(1'b0, 1'b1);
    endtask
endmodule
`default_nettype wire

// file: testbench/tsm_core_test.sv
// Self-checking bench of the temperature sensor serial core
`timescale 1ns/1ps
`default_nettype none
module tsm_core_test;
    import tsm_pkg::*;
    localparam int MEAS = 5000;
    logic sys_clk, rstn, diodeOpen, diodeShort, sclDrv, sdaDrv, k;
    logic smbDatOut, smbDatOeN, alertOut, alertOeN, critOut, critOeN;
    logic [10:0] remoteSample;
    logic [7:0] localSample, got;
    logic [15:0] rw;
    logic [2:0] acks;
    logic [31:0] seed;
    int err_count = 0;
    int samples_checked = 0;
    wire logic sdaWire;
    logic [7:0] defCmd [9] = '{RD_CONFIG, RD_RATE, RD_LOCAL_HIGH, RD_LOCAL_LOW,
        RD_REMOTE_HIGH, RD_REMOTE_LOW, RW_REMOTE_CRIT, RW_LOCAL_CRIT, RW_FILTER};
    logic [7:0] defVal [9] = '{8'h00, 8'h08, 8'h46, 8'h00, 8'h46, 8'h00, 8'h55,
        8'h55, 8'h00};
    logic [7:0] wrCmd [6] = '{WR_LOCAL_HIGH, WR_LOCAL_LOW, WR_REMOTE_HIGH,
        WR_REMOTE_LOW, RW_REMOTE_CRIT, RW_LOCAL_CRIT};
    logic [7:0] wideVal [6] = '{8'h7f, 8'h80, 8'h7f, 8'h80, 8'h7f, 8'h7f};
    // Open-drain data line with pull-up
    assign sdaWire = smbDatOeN & sdaDrv;
    tsm_core #(.MEAS_CYC(MEAS), .TIMEOUT_CYC(300)) tsm_core_i (
        .sys_clk(sys_clk), .rstn(rstn), .smbClkIn(sclDrv), .smbDatIn(sdaWire),
        .smbDatOut(smbDatOut), .smbDatOeN(smbDatOeN),
        .remoteSample(remoteSample), .localSample(localSample),
        .diodeOpen(diodeOpen), .diodeShort(diodeShort), .alertOut(alertOut),
        .alertOeN(alertOeN), .critOut(critOut), .critOeN(critOeN));
    tsm_host tsm_host_i (.sys_clk(sys_clk), .sdaWire(sdaWire),
        .sclDrv(sclDrv), .sdaDrv(sdaDrv));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Remote reading left-justified in a 16-bit word
    function automatic logic [15:0] remWord(input logic [10:0] t);
        return {t, 5'h00};
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [7:0] c, input logic [7:0] e);
        tsm_host_i.rdReg(c, got);
        chk(got, e);
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        tsm_host_i.wrReg(c, d, acks);
        chk({5'h00, acks}, 8'h00);
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever
            #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        #2_000_000;
        err_count++;
        finish_test();
    end
    initial
    begin
        rstn = 1'b0;
        diodeOpen = 1'b0;
        diodeShort = 1'b0;
        remoteSample = 11'h123;
        localSample = 8'h45;
        seed = 32'haa96;
        tsm_host_i.wt(10);
        rstn <= 1'b1;
        tsm_host_i.wt(4);
        rc(RD_LOCAL, 8'h00);
        rc(RD_REMOTE_HI, 8'h00);
        rc(RD_REMOTE_LO, 8'h00);
        for (int i = 0; i < 9; i++)
            rc(defCmd[i], defVal[i]);
        $display("test defaults done");
        for (int i = 0; i < 7; i++)
        begin
            tsm_host_i.edges(1'b1, 1'b0);
            tsm_host_i.xfer({SLAVE_ADDR ^ (7'h01 << i), 1'b0}, 1'b1, got, k);
            tsm_host_i.edges(1'b0, 1'b1);
            chk({7'h00, k}, 8'h01);
        end
        $display("test address done");
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            wr(wrCmd[i], seed[7:0]);
            rc(defCmd[i + 2], seed[7:0]);
            wr(wrCmd[i], wideVal[i]);
        end
        rw = remWord(remoteSample);
        wr(RD_REMOTE_HI, 8'hff);
        rc(RD_REMOTE_HI, rw[15:8]);
        rc(8'h30, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            wr(RW_FILTER, 8'(c * 2));
            rc(RW_FILTER, 8'(c * 2));
        end
        wr(RW_FILTER, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 2; i++)
        begin
            seed = lfsr(seed);
            remoteSample <= (i == 0) ? 11'h400 : seed[10:0];
            localSample <= (i == 0) ? 8'h80 : seed[18:11];
            tsm_host_i.wt(MEAS + 10);
            rw = remWord(remoteSample);
            // inputs held so both bytes share a conversion
            rc(RD_REMOTE_HI, rw[15:8]);
            rc(RD_REMOTE_LO, rw[7:0]);
            rc(RD_LOCAL, localSample);
        end
        $display("test formats done");
        tsm_host_i.rdReg(RD_STATUS, got);
        diodeOpen <= 1'b1;
        tsm_host_i.wt(MEAS + 10);
        chk({6'h00, alertOeN, critOeN}, 8'h03);
        rc(RD_REMOTE_HI, 8'h7f);
        rc(RD_REMOTE_LO, 8'h00);
        tsm_host_i.rdReg(RD_STATUS, got);
        chk({1'b0, got[6:0]}, 8'h04);
        diodeOpen <= 1'b0;
        diodeShort <= 1'b1;
        tsm_host_i.wt(MEAS + 10);
        rc(RD_REMOTE_HI, 8'h80);
        tsm_host_i.rdReg(RD_STATUS, got);
        chk({7'h00, got[ST_OPEN]}, 8'h00);
        $display("test diode done");
        diodeShort <= 1'b0;
        remoteSample <= 11'h100;
        wr(WR_CONFIG, 8'h01);
        wr(WR_REMOTE_HIGH, 8'h10);
        tsm_host_i.rdReg(RD_STATUS, got);
        tsm_host_i.wt(MEAS);
        tsm_host_i.rdReg(RD_STATUS, got);
        chk({7'h00, got[ST_RHIGH]}, 8'h00);
        tsm_host_i.wt(2 * MEAS);
        chk({7'h00, alertOeN}, 8'h00);
        tsm_host_i.rdReg(RD_STATUS, got);
        chk({7'h00, got[ST_RHIGH]}, 8'h01);
        $display("test queue done");
        tsm_host_i.edges(1'b1, 1'b0);
        tsm_host_i.xfer({SLAVE_ADDR, 1'b0}, 1'b1, got, k);
        tsm_host_i.xfer(WR_LOCAL_HIGH, 1'b1, got, k);
        for (int i = 0; i < 4; i++)
            tsm_host_i.bitx(1'b0, k);
        rc(RD_LOCAL_HIGH, 8'h7f);
        tsm_host_i.edges(1'b1, 1'b0);
        tsm_host_i.xfer({SLAVE_ADDR, 1'b1}, 1'b1, got, k);
        tsm_host_i.xfer(8'hff, 1'b0, got, k);
        chk(got, 8'h7f);
        tsm_host_i.xfer(8'hff, 1'b1, got, k);
        chk(got, 8'h7f);
        tsm_host_i.edges(1'b0, 1'b1);
        tsm_host_i.edges(1'b1, 1'b0);
        tsm_host_i.xfer({SLAVE_ADDR, 1'b1}, 1'b1, got, k);
        tsm_host_i.holdLow(8);
        chk({7'h00, smbDatOeN}, 8'h00);
        tsm_host_i.holdLow(400);
        chk({7'h00, smbDatOeN}, 8'h01);
        tsm_host_i.edges(1'b0, 1'b1);
        rc(RD_LOCAL, localSample);
        chk({5'h00, smbDatOut, alertOut, critOut}, 8'h00);
        $display("test bus done");
        finish_test();
    end
endmodule
`default_nettype wire
